/* rtl/sisq_defines.vh */
`ifndef SISQ_DEFINES_VH
`define SISQ_DEFINES_VH
`define SISQ_CLK_HZ        100000000
`define SISQ_BLINK_MS      250
`define SISQ_HALF_CYCLES   24'hbebc20
`define SISQ_CNT_W         24
`define SISQ_CNT_RESET     24'h000000
`define SISQ_BLINK_RESET   1'b0
`define SISQ_LAMP_RESET    1'b0
`define SISQ_SYNC_RESET    1'b0
`define SISQ_ST_WAIT       3'h1
`define SISQ_ST_RUN        3'h2
`define SISQ_ST_LOST       3'h4
`define SISQ_MODE_RESET    1'b0
`endif

/* rtl/sisq_status_indicator.v */
`include "sisq_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module sisq_status_indicator #(
  parameter [`SISQ_CNT_W-1:0] HALF_CYCLES = `SISQ_HALF_CYCLES
) (
  input  wire sys_clk,
  input  wire resetn,
  input  wire power_good,
  input  wire init_done,
  input  wire init_error,
  input  wire link_up,
  input  wire module_fault,
  input  wire cal_mode,
  input  wire cal_active,
  output reg  green_lamp,
  output reg  yellow_lamp
);
  // one-hot communication states
  localparam [2:0] ST_WAIT = `SISQ_ST_WAIT;
  localparam [2:0] ST_RUN  = `SISQ_ST_RUN;
  localparam [2:0] ST_LOST = `SISQ_ST_LOST;

  // bit positions inside the synchronised pin word
  localparam integer SY_RUN   = 0;
  localparam integer SY_MODE  = 1;
  localparam integer SY_FAULT = 2;
  localparam integer SY_LINK  = 3;
  localparam integer SY_ERR   = 4;
  localparam integer SY_DONE  = 5;
  localparam integer SY_PWR   = 6;
  localparam integer SY_W     = 7;

  // raw pin word gathered for the synchroniser
  wire [SY_W-1:0] pins_raw;
  assign pins_raw[SY_RUN]   = cal_active;
  assign pins_raw[SY_MODE]  = cal_mode;
  assign pins_raw[SY_FAULT] = module_fault;
  assign pins_raw[SY_LINK]  = link_up;
  assign pins_raw[SY_ERR]   = init_error;
  assign pins_raw[SY_DONE]  = init_done;
  assign pins_raw[SY_PWR]   = power_good;

  // two flops per pin, first stage read only by the second
  wire [SY_W-1:0] pins_s;
  genvar gi;
  generate
    for (gi = 0; gi < SY_W; gi = gi + 1) begin : g_sync
      reg meta_q;
      reg sync_q;
      always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          meta_q <= `SISQ_SYNC_RESET;
          sync_q <= `SISQ_SYNC_RESET;
        end else begin
          meta_q <= pins_raw[gi];
          sync_q <= meta_q;
        end
      end
      assign pins_s[gi] = sync_q;
    end
  endgenerate

  // synchronised pin levels
  wire pwr_s   = pins_s[SY_PWR];
  wire done_s  = pins_s[SY_DONE];
  wire err_s   = pins_s[SY_ERR];
  wire link_s  = pins_s[SY_LINK];
  wire fault_s = pins_s[SY_FAULT];
  wire mode_s  = pins_s[SY_MODE];
  wire run_s   = pins_s[SY_RUN];

  // module powered and free of faults
  wire lamps_ok;
  assign lamps_ok = pwr_s && !fault_s;

  // divider: one-cycle pulse at the end of every half period
  reg  [`SISQ_CNT_W-1:0] cnt_q;
  reg  [`SISQ_CNT_W-1:0] cnt_d;
  wire                   half_tick;
  assign half_tick = (cnt_q == HALF_CYCLES - 1'b1);

  // next count, wraps on the pulse
  always @* begin
    if (half_tick) begin
      cnt_d = `SISQ_CNT_RESET;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  // divider counter
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= `SISQ_CNT_RESET;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // shared blink wave, toggled on each pulse
  reg blink_q;
  reg blink_d;
  always @* begin
    blink_d = blink_q;
    if (half_tick) begin
      blink_d = ~blink_q;
    end
  end

  // blink register, free running from reset
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      blink_q <= `SISQ_BLINK_RESET;
    end else begin
      blink_q <= blink_d;
    end
  end

  // communication state, next value
  reg [2:0] st_q;
  reg [2:0] st_d;
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_WAIT: begin
        if (done_s && !err_s) begin
          if (link_s) begin
            st_d = ST_RUN;
          end else begin
            st_d = ST_LOST;
          end
        end
      end
      ST_RUN: begin
        if (!link_s) begin
          st_d = ST_LOST;
        end
      end
      ST_LOST: begin
        if (link_s) begin
          st_d = ST_RUN;
        end
      end
      default: begin
        st_d = ST_WAIT;
      end
    endcase
    // power loss restarts the wait for initialization
    if (!pwr_s) begin
      st_d = ST_WAIT;
    end
  end

  // communication state register
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST_WAIT;
    end else begin
      st_q <= st_d;
    end
  end

  // mode follows the pin only while waiting
  reg mode_q;
  reg mode_d;
  always @* begin
    mode_d = mode_q;
    if (st_q == ST_WAIT) begin
      mode_d = mode_s;
    end
  end

  // mode register, frozen once the state leaves ST_WAIT
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= `SISQ_MODE_RESET;
    end else begin
      mode_q <= mode_d;
    end
  end

  // green lamp: dark, steady or blinking
  reg green_d;
  always @* begin
    if (!lamps_ok) begin
      green_d = 1'b0;
    end else if (st_q == ST_RUN) begin
      green_d = 1'b1;
    end else begin
      green_d = blink_q;
    end
  end

  // yellow lamp: only lit in calibration mode with the link up
  reg yellow_d;
  always @* begin
    if (!mode_q) begin
      yellow_d = 1'b0;
    end else if (!lamps_ok) begin
      yellow_d = 1'b0;
    end else if (st_q != ST_RUN) begin
      yellow_d = 1'b0;
    end else if (run_s) begin
      yellow_d = 1'b1;
    end else begin
      yellow_d = blink_q;
    end
  end

  // registered lamp outputs
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      green_lamp  <= `SISQ_LAMP_RESET;
      yellow_lamp <= `SISQ_LAMP_RESET;
    end else begin
      green_lamp  <= green_d;
      yellow_lamp <= yellow_d;
    end
  end
endmodule
`default_nettype wire

/* verification/sisq_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module sisq_checker #(parameter int HALF_CYCLES = 4) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic power_good,
  input wire logic init_done,
  input wire logic init_error,
  input wire logic link_up,
  input wire logic module_fault,
  input wire logic cal_active,
  input wire logic green_lamp,
  input wire logic yellow_lamp
);
  // short aliases for the lamps and a healthy-module flag
  wire g = green_lamp, y = yellow_lamp, k = link_up, u = power_good && !module_fault;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_lost; (u && !k)[*5] ##1 (u && !k)[*5]; endsequence
  sequence s_run; y ##1 (u && k && cal_active)[*6]; endsequence
  sequence s_idle; y ##1 (u && k && !cal_active)[*5] ##1 (u && k && !cal_active)[*5]; endsequence
  a_fault_dark: assert property (module_fault[*6] |-> !g && !y) else $error("lit");
  a_power_dark: assert property (!power_good[*6] |-> !g && !y) else $error("lit");
  a_link_dark: assert property (!k[*6] |-> !y) else $error("lit");
  a_link_past: assert property (y |-> $past(k, 4)) else $error("lit");
  a_green_blink: assert property (s_lost |-> g != $past(g, HALF_CYCLES)) else $error("no blink");
  a_green_on: assert property ((u && k && init_done && !init_error)[*7] |-> g) else $error("off");
  a_cal_on: assert property (s_run |-> y) else $error("off");
  a_cal_blink: assert property (s_idle |-> y != $past(y, HALF_CYCLES)) else $error("no blink");
endmodule
`default_nettype wire

/* verification/sisq_partner.sv */
`timescale 1ns/10ps
`default_nettype none
// controller link, dropped on request
module sisq_partner (input wire logic sys_clk, input wire logic drop, output logic link_up);
  always @(negedge sys_clk) link_up <= !drop;
endmodule
`default_nettype wire

/* verification/status_indicator_sequencer_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a,b) begin checks++; if ((a)!==(b)) begin failures++; $display("mismatch %0t lamp",$time); end end
module status_indicator_sequencer_bench;
  logic sys_clk=0, resetn=0, power_good=0, init_done=0, init_error=0, cal_mode=0, cal_active=0, module_fault=0;
  logic drop=0, link_up, green_lamp, yellow_lamp, g, y;
  bit [3:0] q[$], e;
  int failures=0, checks=0, i;
  // steps: inputs {pwr,init,err,mode,run,fault,drop}, lamps {green,yellow}: 0 off, 1 on, 2 blink
  bit [10:0] t[12]='{11'h488, 11'h788, 11'h686, 11'h6c5, 11'h6d8, 11'h606, 11'h420, 11'h200, 11'h604, 11'h644,
    11'h618, 11'h604};
  sisq_status_indicator #(.HALF_CYCLES(24'h4)) i_sisq_status_indicator (.sys_clk(sys_clk), .resetn(resetn),
    .power_good(power_good), .init_done(init_done), .init_error(init_error), .link_up(link_up),
    .module_fault(module_fault), .cal_mode(cal_mode), .cal_active(cal_active), .green_lamp(green_lamp),
    .yellow_lamp(yellow_lamp));
  sisq_partner i_sisq_partner (.sys_clk(sys_clk), .drop(drop), .link_up(link_up));
  task tally_and_finish;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial forever #5 sys_clk = !sys_clk;
  initial begin #20000 failures++; tally_and_finish; end
  // driver: apply a step at the falling edge, note the lamps it should give
  initial begin
    void'($urandom(32'h91598a81));
    repeat (16) @(negedge sys_clk);
    resetn = 1;
    for (i = 0; i < 12; i++) begin
      {power_good, init_done, init_error, cal_mode, cal_active, module_fault, drop} = t[i][10:4] |
        (i == 6 ? 7'($urandom) & 7'h3c : 7'h0);
      repeat (10) @(negedge sys_clk);
      q.push_back(t[i][3:0]);
      repeat (6) @(negedge sys_clk);
    end
    tally_and_finish;
  end
  // watcher: snapshot, look again half a blink later
  always @(negedge sys_clk) if (q.size() > 0) begin
    e = q.pop_front();
    g = green_lamp;
    y = yellow_lamp;
    #40 `CHK({g, green_lamp}, e[3] ? (g ? 2'b10 : 2'b01) : {2{e[2]}})
    `CHK({y, yellow_lamp}, e[1] ? (y ? 2'b10 : 2'b01) : {2{e[0]}})
  end
endmodule
bind sisq_status_indicator sisq_checker #(.HALF_CYCLES(HALF_CYCLES)) u_chk (.*);
`default_nettype wire
